// *** hw/compare_pwm_timer.sv ***
/*
  Up-counting 32-bit timer with compare, PWM output, event flags, idle and
  wake-up handshake, debug freeze, 16-bit split access and posted writes.
  Assumes one 250 MHz clock for both interface and timer, and a host that holds
  each request until SCmdAccept.
*/
// Summary of operation
// RQ1 - With compare enabled, each count is compared with match_value, rewritable anytime.
// RQ2 - A match sets the match flag; interrupt only when match_irq_enable set.
// RQ3 - Overflow and match events pulse or toggle the PWM output per output_style.
// RQ4 - Prescaler divides only when divider_enable, control bit 5, is set.
// RQ5 - Divisor 1 when disabled, else 2 to the (divider_power plus one).
// RQ6 - Prescaler count clears when the counter stops or reloads while running.
// RQ7 - Auto-reload overflow or trigger loads reload_value, one-shot overflow loads zero and stops, counter write loads data, stop freezes.
// RQ8 - Software changes pwm_idle_level only while stopped or trigger off.
// RQ9 - Clearing output_event_select stops modulation at the next overflow.
// RQ10 - Overflow after all-ones minus reload_value plus one counts; match at match_value.
// RQ11 - Software keeps reload and match values at least two below overflow.
// RQ12 - Events set sticky flags; writing one clears a flag.
// RQ13 - Idle acknowledge follows idle_policy: never, at once, or when nothing pending.
// RQ14 - Asleep in smart idle, enabled events raise wake-up only if wake_enable.
// RQ15 - Host drops idle request, acknowledge drops; clearing the flag releases wake-up.
// RQ16 - In debug, debug_run_free keeps counting; otherwise prescaler and counter freeze.
// RQ17 - The capture input pin passes a two-flop synchroniser.
// RQ18 - A 16-bit low read of the counter captures the count for the high read.
// RQ19 - Host writes 32-bit registers as low half then high half.
// RQ20 - Posted writes ack at once, pend per register; a new write replaces it.
// RQ21 - Posted mode only when timer clock is at most a quarter of interface clock.
// RQ22 - Non-posted accesses stall three interface plus five timer clocks.
// RQ23 - Interrupt sources merge into one interrupt, wake sources into one wake-up.
// RQ24 - output_event_select: 00 none, 01 overflow, 10 overflow and match.
// RQ25 - output_style 0 gives a single pulse, 1 a toggle.
// RQ26 - idle_policy: 00 force idle, 01 no idle, 10 smart idle.
`timescale 1ns/10ps
`default_nettype none
module compare_pwm_timer (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [2:0] MCmd,
  input wire logic [timer_pkg::ADDR_W-1:0] MAddr,
  input wire logic [31:0] MData,
  input wire logic [3:0] MByteEn,
  output logic SCmdAccept,
  output logic [1:0] SResp,
  output logic [31:0] SData,
  input wire logic idle_request,
  input wire logic debug_suspend,
  input wire logic event_capture_pin,
  output logic idle_ack,
  output logic wake_request,
  output logic irq,
  output logic pwm_out
);
  import timer_pkg::*;

  typedef enum logic [1:0] {BUS_IDLE, BUS_WAIT, BUS_RESP} bus_state_t;

  bus_state_t state;
  logic [3:0] wait_cnt;
  logic req_wr;
  logic [ADDR_W-1:0] req_addr;
  logic [31:0] req_data;
  logic [3:0] req_be;
  logic take, go, wr_go, rd_go;
  logic [31:0] rd_word, wr_word;
  logic rd_ok;
  logic [2:0] req_slot;
  logic posted;
  logic [SLOTS-1:0] pending, commit;
  logic [31:0] shadow [SLOTS];
  logic [31:0] cdata [SLOTS];
  logic [2:0] sync_cnt;
  logic sync_done;
  logic cfg_free, cfg_wake, cfg_autoidle;
  logic [1:0] cfg_idle;
  logic [2:0] flags, irq_en, wake_en, flag_set, flag_clr;
  logic [CTL_W-1:0] ctl;
  logic [31:0] counter_value, reload_value, match_value, captured_value, next_count;
  logic [15:0] hold_hi;
  logic frozen, running, tick, count_en, ovf_hit, match_hit;
  logic cap_meta, cap_sync, cap_prev, cap_edge, cap_hit;
  logic mod_active, pwm_event, asleep;
  logic [1:0] held_sel, eff_sel;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data, input logic [3:0] be);
    logic [31:0] m;
    m = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        m[8*b +: 8] = data[8*b +: 8];
      end
    end
    return m;
  endfunction

  function automatic logic [2:0] slot_of(input logic [ADDR_W-1:0] a);
    unique case (a)
      OFF_CONTROL: return SLOT_CTL;
      OFF_COUNT: return SLOT_CNT;
      OFF_RELOAD: return SLOT_LOAD;
      OFF_TRIGGER: return SLOT_TRIG;
      OFF_MATCH: return SLOT_MATCH;
      default: return SLOT_NONE;
    endcase
  endfunction

  // ==========================================================================
  // Register bus slave
  assign take = (state == BUS_IDLE) && (MCmd == OCP_WR || MCmd == OCP_RD);
  assign go = (state == BUS_WAIT) && (wait_cnt == 4'h0);
  assign wr_go = go && req_wr;
  assign rd_go = go && !req_wr;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state <= BUS_IDLE;
      wait_cnt <= 4'h0;
      req_wr <= 1'b0;
      req_addr <= '0;
      req_data <= 32'h00000000;
      req_be <= 4'h0;
    end else begin
      unique case (state)
        BUS_IDLE: if (take) begin
          req_wr <= (MCmd == OCP_WR);
          req_addr <= MAddr;
          req_data <= MData;
          req_be <= MByteEn;
          // Non-posted accesses wait for the timer-side resync
          wait_cnt <= posted ? 4'(POSTED_CYCLES - 1) : 4'(STALL_CYCLES - 1); // RQ20 RQ22
          state <= BUS_WAIT;
        end
        BUS_WAIT: if (wait_cnt == 4'h0) begin
          state <= BUS_RESP;
        end else begin
          wait_cnt <= wait_cnt - 4'h1;
        end
        BUS_RESP: state <= BUS_IDLE;
      endcase
    end
  end

  always_comb begin
    rd_ok = 1'b1;
    rd_word = 32'h00000000;
    unique case (req_addr)
      OFF_REVISION: rd_word = {24'h000000, REVISION};
      OFF_CONFIG: rd_word = {26'h0, cfg_free, cfg_idle, cfg_wake, 1'b0, cfg_autoidle};
      OFF_RESET_DONE: rd_word = 32'h00000001;
      OFF_FLAGS: rd_word = {29'h0, flags};
      OFF_IRQ_EN: rd_word = {29'h0, irq_en};
      OFF_WAKE_EN: rd_word = {29'h0, wake_en};
      OFF_CONTROL: rd_word = {19'h0, ctl};
      OFF_COUNT: rd_word = counter_value;
      OFF_RELOAD: rd_word = reload_value;
      OFF_TRIGGER: rd_word = 32'h00000000;
      OFF_PENDING: rd_word = {27'h0, pending};
      OFF_MATCH: rd_word = match_value;
      OFF_CAPTURED: rd_word = captured_value;
      OFF_SYNC_CTL: rd_word = {29'h0, posted, 2'h0};
      default: rd_ok = 1'b0;
    endcase
  end

  // Unselected byte lanes keep their value, so 16-bit halves merge
  assign wr_word = merge(rd_word, req_data, req_be); // RQ19
  assign req_slot = slot_of(req_addr);

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      SCmdAccept <= 1'b0;
      SResp <= RESP_NULL;
      SData <= 32'h00000000;
      hold_hi <= 16'h0000;
    end else begin
      SCmdAccept <= go;
      SResp <= go ? (rd_ok ? RESP_DVA : RESP_ERR) : RESP_NULL;
      if (rd_go && req_addr == OFF_COUNT && req_be == BE_HI) begin
        SData <= {hold_hi, 16'h0000}; // RQ18
      end else begin
        SData <= rd_go ? rd_word : 32'h00000000;
      end
      if (rd_go && req_addr == OFF_COUNT && req_be == BE_LO) begin
        hold_hi <= counter_value[31:16]; // RQ18
      end
    end
  end

  // Interface-side registers take effect at once
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cfg_free <= 1'b0;
      cfg_idle <= IDLE_RESET;
      cfg_wake <= 1'b0;
      cfg_autoidle <= 1'b0;
      irq_en <= 3'h0;
      wake_en <= 3'h0;
      posted <= POSTED_RESET;
    end else if (wr_go) begin
      if (req_addr == OFF_CONFIG) begin
        cfg_free <= wr_word[CFG_FREE];
        cfg_idle <= wr_word[CFG_IDLE_LO +: 2];
        cfg_wake <= wr_word[CFG_WAKE];
        cfg_autoidle <= wr_word[CFG_AUTOIDLE];
      end
      if (req_addr == OFF_IRQ_EN) irq_en <= wr_word[2:0];
      if (req_addr == OFF_WAKE_EN) wake_en <= wr_word[2:0];
      if (req_addr == OFF_SYNC_CTL) posted <= wr_word[SIC_POSTED];
    end
  end

  // ==========================================================================
  // Write posting toward the timer side
  assign sync_done = (sync_cnt == 3'h1);

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sync_cnt <= 3'h0;
    end else if (wr_go && posted && req_slot != SLOT_NONE) begin
      sync_cnt <= SYNC_CYCLES; // RQ20
    end else if (sync_cnt != 3'h0) begin
      sync_cnt <= sync_cnt - 3'h1;
    end
  end

  for (genvar k = 0; k < SLOTS; k++) begin : g_slot
    logic hit;
    assign hit = wr_go && (req_slot == 3'(k));
    assign commit[k] = (sync_done && pending[k]) || (hit && !posted); // RQ22
    assign cdata[k] = (sync_done && pending[k]) ? shadow[k] : wr_word;
    always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
        pending[k] <= 1'b0;
        shadow[k] <= 32'h00000000;
      end else if (hit && posted) begin
        // A later write silently replaces the one still pending
        pending[k] <= 1'b1; // RQ20
        shadow[k] <= wr_word;
      end else if (sync_done) begin
        pending[k] <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Counter, prescaler and compare
  assign frozen = debug_suspend && !cfg_free; // RQ16
  assign running = ctl[CTL_START] && !frozen;
  assign count_en = running && tick;
  assign ovf_hit = count_en && (counter_value == COUNT_MAX); // RQ10
  assign next_count = ovf_hit ? (ctl[CTL_AUTO] ? reload_value : 32'h00000000) : counter_value + 32'h1;
  assign match_hit = count_en && ctl[CTL_CMP_EN] && (next_count == match_value); // RQ1 RQ10

  timer_prescaler u_prescaler (
    .clock(clock),
    .rstn(rstn),
    .run(running),
    .clear(!ctl[CTL_START] || commit[SLOT_TRIG] || commit[SLOT_CNT] || ovf_hit), // RQ6 RQ7
    .divider_enable(ctl[CTL_DIV_EN]),
    .divider_power(ctl[CTL_DIV_PWR_LO +: 3]),
    .tick(tick)
  );

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ctl <= CTL_RESET;
      reload_value <= 32'h00000000;
      match_value <= 32'h00000000;
    end else begin
      if (commit[SLOT_CTL]) begin
        ctl <= cdata[SLOT_CTL][CTL_W-1:0];
      end else if (ovf_hit && !ctl[CTL_AUTO]) begin
        ctl[CTL_START] <= 1'b0;
      end
      if (commit[SLOT_LOAD]) reload_value <= cdata[SLOT_LOAD];
      if (commit[SLOT_MATCH]) match_value <= cdata[SLOT_MATCH]; // RQ1
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      counter_value <= 32'h00000000;
    end else if (commit[SLOT_CNT]) begin
      counter_value <= cdata[SLOT_CNT]; // RQ7
    end else if (commit[SLOT_TRIG]) begin
      counter_value <= reload_value; // RQ7
    end else if (count_en) begin
      counter_value <= next_count; // RQ7
    end
  end

  // ==========================================================================
  // Capture input and event flags
  always_comb begin
    unique case (ctl[CTL_CAP_LO +: 2])
      CAP_RISE: cap_edge = cap_sync && !cap_prev;
      CAP_FALL: cap_edge = !cap_sync && cap_prev;
      CAP_BOTH: cap_edge = cap_sync ^ cap_prev;
      default: cap_edge = 1'b0;
    endcase
  end
  // Only the first edge is kept until software clears the flag
  assign cap_hit = cap_edge && !flags[EV_CAP];

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cap_meta <= 1'b0;
      cap_sync <= 1'b0;
      cap_prev <= 1'b0;
      captured_value <= 32'h00000000;
    end else begin
      cap_meta <= event_capture_pin; // RQ17
      cap_sync <= cap_meta; // RQ17
      cap_prev <= cap_sync;
      if (cap_hit) captured_value <= counter_value;
    end
  end

  assign flag_set = {cap_hit, ovf_hit, match_hit};
  assign flag_clr = (wr_go && req_addr == OFF_FLAGS && req_be[0]) ? req_data[2:0] : 3'h0;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      flags <= 3'h0;
    end else begin
      // A new event wins over a clear in the same cycle
      flags <= (flags & ~flag_clr) | flag_set; // RQ2 RQ12
    end
  end

  // ==========================================================================
  // PWM output
  assign eff_sel = (ctl[CTL_SEL_LO +: 2] != SEL_NONE) ? ctl[CTL_SEL_LO +: 2] : held_sel;
  assign pwm_event = mod_active && ((ovf_hit && (eff_sel == SEL_OVF || eff_sel == SEL_OVF_MATCH))
                     || (match_hit && eff_sel == SEL_OVF_MATCH)); // RQ3 RQ24

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      mod_active <= 1'b0;
      held_sel <= SEL_NONE;
      pwm_out <= 1'b0;
    end else begin
      if (ctl[CTL_SEL_LO +: 2] != SEL_NONE) begin
        mod_active <= 1'b1;
        held_sel <= ctl[CTL_SEL_LO +: 2];
      end else if (ovf_hit) begin
        mod_active <= 1'b0; // RQ9
      end
      if (!mod_active) begin
        pwm_out <= ctl[CTL_IDLE_LVL];
      end else if (pwm_event) begin
        pwm_out <= ctl[CTL_STYLE] ? !pwm_out : !ctl[CTL_IDLE_LVL]; // RQ3 RQ25
      end else if (!ctl[CTL_STYLE]) begin
        pwm_out <= ctl[CTL_IDLE_LVL];
      end
    end
  end

  // ==========================================================================
  // Interrupt, idle and wake-up
  assign asleep = idle_ack && (cfg_idle == IDLE_SMART);

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      irq <= 1'b0;
      idle_ack <= 1'b0;
      wake_request <= 1'b0;
    end else begin
      irq <= |(flags & irq_en); // RQ2 RQ23
      idle_ack <= idle_request && ((cfg_idle == IDLE_FORCE)
                  || (cfg_idle == IDLE_SMART && (idle_ack || flags == 3'h0))); // RQ13 RQ15 RQ26
      // Held after the host wakes until the causing flag is cleared
      wake_request <= cfg_wake && |(flags & wake_en) && (asleep || wake_request); // RQ14 RQ15 RQ23
    end
  end

  // ==========================================================================
  // Checks
  property p_match_flag;
    @(posedge clock) disable iff (!rstn) match_hit |=> flags[EV_MATCH];
  endproperty
  a_match_flag: assert property (p_match_flag) else $error("match did not set flag"); // RQ2

  property p_irq_merge;
    @(posedge clock) disable iff (!rstn) (flags[EV_MATCH] && irq_en[EV_MATCH]) |=> irq;
  endproperty
  a_irq_merge: assert property (p_irq_merge) else $error("enabled flag without interrupt"); // RQ23

  property p_pulse;
    @(posedge clock) disable iff (!rstn)
      (pwm_event && !ctl[CTL_STYLE] && ctl[CTL_STYLE] == $past(ctl[CTL_STYLE])) |=> (pwm_out != ctl[CTL_IDLE_LVL]);
  endproperty
  a_pulse: assert property (p_pulse) else $error("pulse mode gave no pulse"); // RQ3

  property p_toggle;
    @(posedge clock) disable iff (!rstn) (pwm_event && ctl[CTL_STYLE]) |=> (pwm_out != $past(pwm_out));
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle mode did not invert"); // RQ25

  property p_freeze;
    @(posedge clock) disable iff (!rstn)
      ((frozen || !ctl[CTL_START]) && !commit[SLOT_CNT] && !commit[SLOT_TRIG]) |=> $stable(counter_value);
  endproperty
  a_freeze: assert property (p_freeze) else $error("counter moved while frozen"); // RQ16

  property p_divider;
    @(posedge clock) disable iff (!rstn) (tick && ctl[CTL_DIV_EN] && $stable(ctl)) |=> !tick;
  endproperty
  a_divider: assert property (p_divider) else $error("divider gave ticks back to back"); // RQ5

  property p_stall;
    @(posedge clock) disable iff (!rstn) (take && !posted) |=> !SCmdAccept [*8] ##1 SCmdAccept;
  endproperty
  a_stall: assert property (p_stall) else $error("non-posted stall length wrong"); // RQ22

  property p_posted_ack;
    @(posedge clock) disable iff (!rstn) (take && posted) |=> !SCmdAccept ##1 SCmdAccept;
  endproperty
  a_posted_ack: assert property (p_posted_ack) else $error("posted access not answered at once"); // RQ20

  property p_no_idle;
    @(posedge clock) disable iff (!rstn) (cfg_idle == IDLE_NONE) |=> !idle_ack;
  endproperty
  a_no_idle: assert property (p_no_idle) else $error("idle acknowledged in no-idle"); // RQ13

  property p_wake_gate;
    @(posedge clock) disable iff (!rstn) $rose(wake_request) |-> $past(cfg_wake && asleep);
  endproperty
  a_wake_gate: assert property (p_wake_gate) else $error("wake-up without permission"); // RQ14

  property p_sync_pin;
    @(posedge clock) disable iff (!rstn) ##2 (cap_sync == $past(event_capture_pin, 2));
  endproperty
  a_sync_pin: assert property (p_sync_pin) else $error("capture pin sync depth wrong"); // RQ17

  c_posted_write: cover property (@(posedge clock) disable iff (!rstn) wr_go && posted ##[1:8] sync_done);
  c_stalled_read: cover property (@(posedge clock) disable iff (!rstn) rd_go && !posted);
  c_pwm_toggle: cover property (@(posedge clock) disable iff (!rstn) pwm_event && ctl[CTL_STYLE]);
  c_wake: cover property (@(posedge clock) disable iff (!rstn) $rose(wake_request));

endmodule
`default_nettype wire

// *** hw/timer_pkg.sv ***
/*
  Shared constants of the compare/PWM timer: register offsets, field positions,
  encodings, reset values and bus latencies.
  Assumes a byte-addressed register bus with 32-bit data and four byte enables.
*/
package timer_pkg;

  // ==========================================================================
  // Register bus
  localparam int ADDR_W = 8;
  localparam logic [2:0] OCP_IDLE = 3'h0;
  localparam logic [2:0] OCP_WR = 3'h1;
  localparam logic [2:0] OCP_RD = 3'h2;
  localparam logic [1:0] RESP_NULL = 2'h0;
  localparam logic [1:0] RESP_DVA = 2'h1;
  localparam logic [1:0] RESP_ERR = 2'h3;
  localparam logic [3:0] BE_LO = 4'h3;
  localparam logic [3:0] BE_HI = 4'hc;

  // ==========================================================================
  // Register offsets
  localparam logic [7:0] OFF_REVISION = 8'h00;
  localparam logic [7:0] OFF_CONFIG = 8'h10;
  localparam logic [7:0] OFF_RESET_DONE = 8'h14;
  localparam logic [7:0] OFF_FLAGS = 8'h18;
  localparam logic [7:0] OFF_IRQ_EN = 8'h1c;
  localparam logic [7:0] OFF_WAKE_EN = 8'h20;
  localparam logic [7:0] OFF_CONTROL = 8'h24;
  localparam logic [7:0] OFF_COUNT = 8'h28;
  localparam logic [7:0] OFF_RELOAD = 8'h2c;
  localparam logic [7:0] OFF_TRIGGER = 8'h30;
  localparam logic [7:0] OFF_PENDING = 8'h34;
  localparam logic [7:0] OFF_MATCH = 8'h38;
  localparam logic [7:0] OFF_CAPTURED = 8'h3c;
  localparam logic [7:0] OFF_SYNC_CTL = 8'h40;

  // Module revision, value arbitrary
  localparam logic [7:0] REVISION = 8'h10;

  // ==========================================================================
  // interface_config fields and idle policies
  localparam int CFG_AUTOIDLE = 0;
  localparam int CFG_WAKE = 2;
  localparam int CFG_IDLE_LO = 3;
  localparam int CFG_FREE = 5;
  localparam logic [1:0] IDLE_FORCE = 2'h0;
  localparam logic [1:0] IDLE_NONE = 2'h1;
  localparam logic [1:0] IDLE_SMART = 2'h2;
  localparam logic [1:0] IDLE_RESET = 2'h0;

  // Event flag positions
  localparam int EV_MATCH = 0;
  localparam int EV_OVF = 1;
  localparam int EV_CAP = 2;

  // ==========================================================================
  // timer_control fields
  localparam int CTL_START = 0;
  localparam int CTL_AUTO = 1;
  localparam int CTL_DIV_PWR_LO = 2;
  localparam int CTL_DIV_EN = 5;
  localparam int CTL_CMP_EN = 6;
  localparam int CTL_IDLE_LVL = 7;
  localparam int CTL_CAP_LO = 8;
  localparam int CTL_SEL_LO = 10;
  localparam int CTL_STYLE = 12;
  localparam int CTL_W = 13;
  localparam logic [12:0] CTL_RESET = 13'h0000;
  localparam logic [1:0] SEL_NONE = 2'h0;
  localparam logic [1:0] SEL_OVF = 2'h1;
  localparam logic [1:0] SEL_OVF_MATCH = 2'h2;
  localparam logic [1:0] CAP_NONE = 2'h0;
  localparam logic [1:0] CAP_RISE = 2'h1;
  localparam logic [1:0] CAP_FALL = 2'h2;
  localparam logic [1:0] CAP_BOTH = 2'h3;
  localparam logic [31:0] COUNT_MAX = 32'hffffffff;

  // sync_interface_control: write posting enable
  localparam int SIC_POSTED = 2;
  localparam logic POSTED_RESET = 1'b0;

  // Posted slots, one pending bit each
  localparam int SLOTS = 5;
  localparam logic [2:0] SLOT_CTL = 3'h0;
  localparam logic [2:0] SLOT_CNT = 3'h1;
  localparam logic [2:0] SLOT_LOAD = 3'h2;
  localparam logic [2:0] SLOT_TRIG = 3'h3;
  localparam logic [2:0] SLOT_MATCH = 3'h4;
  localparam logic [2:0] SLOT_NONE = 3'h7;

  // ==========================================================================
  // Latencies: interface and timer clocks are both the 250 MHz clock
  localparam int STALL_IF_CLOCKS = 3;
  localparam int STALL_TIMER_CLOCKS = 5;
  localparam int CLOCKS_PER_TIMER_CLOCK = 1;
  localparam int STALL_CYCLES = STALL_IF_CLOCKS + STALL_TIMER_CLOCKS * CLOCKS_PER_TIMER_CLOCK;
  localparam int POSTED_CYCLES = 1;
  localparam logic [2:0] SYNC_CYCLES = 3'(STALL_TIMER_CLOCKS * CLOCKS_PER_TIMER_CLOCK);

endpackage

// *** hw/timer_prescaler.sv ***
/*
  Prescaler of the timer: turns the timer clock into count ticks.
  Assumes run, clear and the divider setting come from the timer core.
*/
`timescale 1ns/10ps
`default_nettype none
module timer_prescaler (
  input wire logic clock,
  input wire logic rstn,
  input wire logic run,
  input wire logic clear,
  input wire logic divider_enable,
  input wire logic [2:0] divider_power,
  output logic tick
);
  import timer_pkg::*;

  logic [7:0] count;
  logic [7:0] limit;

  // Divisor is 2^(power+1): 2 for 0 up to 256 for 7
  assign limit = 8'((9'h002 << divider_power) - 9'h001); // RQ5

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      count <= 8'h00;
      tick <= 1'b0;
    end else if (clear) begin
      count <= 8'h00; // RQ6
      tick <= 1'b0;
    end else if (!run) begin
      tick <= 1'b0; // RQ16
    end else if (!divider_enable) begin
      count <= 8'h00;
      tick <= 1'b1; // RQ4
    end else if (count == limit) begin
      count <= 8'h00;
      tick <= 1'b1; // RQ4
    end else begin
      count <= count + 8'h01;
      tick <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// *** verification/host_model.sv ***
/* Host side of the register bus: one request at a time.
   Assumes a slave that answers with SCmdAccept, SResp and SData. */
`timescale 1ns/10ps
`default_nettype none
module host_model (
  input wire logic clock,
  input wire logic SCmdAccept,
  input wire logic [1:0] SResp,
  input wire logic [31:0] SData,
  output var logic [2:0] MCmd,
  output var logic [timer_pkg::ADDR_W-1:0] MAddr,
  output var logic [31:0] MData,
  output var logic [3:0] MByteEn
);
  import timer_pkg::*;
  initial begin
    MCmd = OCP_IDLE;
    MAddr = 8'h00;
    MData = 32'h0;
    MByteEn = 4'hf;
  end
  // ==========================================================================
  // Held until the edge that samples accept; released data is inverted, not kept
  task automatic xfer(input logic [2:0] cmd, input logic [7:0] addr, input logic [31:0] data,
      input logic [3:0] be, output logic [31:0] rdata, output logic [1:0] resp, output int n);
    @(negedge clock);
    MCmd = cmd;
    MAddr = addr;
    MData = data;
    MByteEn = be;
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (SCmdAccept !== 1'b1 && n < 30);
    rdata = SData;
    resp = SResp;
    @(posedge clock);
    @(negedge clock);
    MCmd = OCP_IDLE;
    MData = ~data;
  endtask
endmodule
`default_nettype wire

// *** verification/test_compare_pwm_timer.sv ***
/* Self-checking bench of the compare/PWM timer.
   Assumes host_model as bus master and one 250 MHz clock. */
`timescale 1ns/10ps
`default_nettype none
module test_compare_pwm_timer;
  import timer_pkg::*;
  logic clock = 0, rstn = 0, idle_request = 0, debug_suspend = 0, event_capture_pin = 0;
  logic [2:0] MCmd;
  logic [7:0] MAddr;
  logic [31:0] MData, SData, rd, rd0;
  logic [3:0] MByteEn, be = 4'hf;
  logic [1:0] pol [3] = '{IDLE_NONE, IDLE_FORCE, IDLE_SMART};
  logic [1:0] SResp, resp;
  logic SCmdAccept, idle_ack, wake_request, irq, pwm_out;
  int n_errors = 0, total_checks = 0, n, t;
  compare_pwm_timer compare_pwm_timer_i (.clock(clock), .rstn(rstn), .MCmd(MCmd), .MAddr(MAddr),
    .MData(MData), .MByteEn(MByteEn), .SCmdAccept(SCmdAccept), .SResp(SResp), .SData(SData),
    .idle_request(idle_request), .debug_suspend(debug_suspend), .event_capture_pin(event_capture_pin),
    .idle_ack(idle_ack), .wake_request(wake_request), .irq(irq), .pwm_out(pwm_out));
  host_model host_model_i (.clock(clock), .SCmdAccept(SCmdAccept), .SResp(SResp), .SData(SData),
    .MCmd(MCmd), .MAddr(MAddr), .MData(MData), .MByteEn(MByteEn));
  initial forever #2 clock = ~clock;
  // ==========================================================================
  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", what, exp, got);
      n_errors++;
    end
  endtask
  task automatic bus(input logic [2:0] cmd, input logic [7:0] a, input logic [31:0] d);
    host_model_i.xfer(cmd, a, d, be, rd, resp, n);
    if (n >= 30) begin
      n_errors++;
      test_done();
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    bus(OCP_RD, a, 32'h0);
    chk("read", exp, rd);
  endtask
  // Waits for pwm_out high; a run-out counts as a mismatch and ends the run
  task automatic wait_pwm();
    for (t = 0; t < 200 && pwm_out !== 1'b1; t++) @(negedge clock);
    if (t >= 200) begin
      n_errors++;
      test_done();
    end
  endtask
  // ==========================================================================
  initial begin
    repeat (10) @(posedge clock);
    @(negedge clock) rstn = 1'b1;
    rdc(OFF_CONTROL, 32'h0);
    chk("stall", STALL_CYCLES + 1, n);
    rdc(OFF_RESET_DONE, 32'h1);
    // Posting stays off: the timer clock is the interface clock here
    rdc(OFF_SYNC_CTL, 32'h0);
    rdc(OFF_REVISION, {24'h0, REVISION});
    bus(OCP_RD, 8'h04, 32'h0);
    chk("unmapped", RESP_ERR, resp);
    bus(OCP_WR, OFF_IRQ_EN, 32'h3);
    be = BE_LO;
    bus(OCP_WR, OFF_RELOAD, 32'h0000fff0);
    be = BE_HI;
    bus(OCP_WR, OFF_RELOAD, 32'hffff0000);
    bus(OCP_WR, OFF_TRIGGER, 32'h0);
    be = BE_LO;
    bus(OCP_RD, OFF_COUNT, 32'h0);
    chk("count low", 32'h0000fff0, {16'h0, rd[15:0]});
    be = BE_HI;
    bus(OCP_RD, OFF_COUNT, 32'h0);
    chk("count high", 32'hffff0000, rd);
    be = 4'hf;
    bus(OCP_WR, OFF_MATCH, 32'hfffffff8);
    // One-shot, divide by 2, compare on, toggle on overflow
    bus(OCP_WR, OFF_CONTROL, 32'h1000 | (SEL_OVF << 10) | 32'h61);
    wait_pwm();
    chk("overflow time", 1, 32'(t >= 28 && t <= 40));
    chk("pwm", 1, pwm_out);
    rdc(OFF_FLAGS, 32'h3);
    rdc(OFF_COUNT, 32'h0);
    rdc(OFF_CONTROL, 32'h1000 | (SEL_OVF << 10) | 32'h60);
    bus(OCP_WR, OFF_FLAGS, 32'h1);
    rdc(OFF_FLAGS, 32'h2);
    chk("irq", 1, irq);
    bus(OCP_WR, OFF_FLAGS, 32'h2);
    chk("irq", 0, irq);
    foreach (pol[i]) begin
      bus(OCP_WR, OFF_CONFIG, 32'(pol[i]) << CFG_IDLE_LO);
      @(negedge clock) idle_request = 1'b1;
      repeat (3) @(negedge clock);
      chk("idle ack", 32'(i != 0), idle_ack);
      idle_request = 1'b0;
      repeat (3) @(negedge clock);
      chk("idle ack", 0, idle_ack);
    end
    // Smart idle, wake on overflow; trigger selection off, so two overflows leave pwm idle
    bus(OCP_WR, OFF_CONFIG, (32'(IDLE_SMART) << CFG_IDLE_LO) | (32'h1 << CFG_WAKE));
    bus(OCP_WR, OFF_WAKE_EN, 32'h2);
    bus(OCP_WR, OFF_TRIGGER, 32'h0);
    @(negedge clock) idle_request = 1'b1;
    bus(OCP_WR, OFF_CONTROL, 32'h1003);
    repeat (40) @(negedge clock);
    chk("idle ack", 1, idle_ack);
    chk("wake", 1, wake_request);
    chk("pwm stopped", 0, pwm_out);
    @(negedge clock) debug_suspend = 1'b1;
    bus(OCP_RD, OFF_COUNT, 32'h0);
    rd0 = rd;
    rdc(OFF_COUNT, rd0);
    debug_suspend = 1'b0;
    bus(OCP_WR, OFF_CONTROL, 32'h1000);
    idle_request = 1'b0;
    repeat (3) @(negedge clock);
    chk("idle ack", 0, idle_ack);
    chk("wake", 1, wake_request);
    bus(OCP_WR, OFF_FLAGS, 32'h7);
    chk("wake", 0, wake_request);
    test_done();
  end
endmodule
`default_nettype wire
